//--- rtl/ac_link_pkg.sv
package ac_link_pkg;
  // Frame geometry
  localparam int unsigned tag_bits = 16;
  localparam int unsigned slot_bits = 20;
  localparam int unsigned num_slots = 12;
  localparam int unsigned frame_bits = tag_bits + num_slots * slot_bits;
  localparam logic [7:0] last_bit = 8'hff;
  localparam logic [7:0] sync_len = 8'h10;
  // Slot numbers
  localparam logic [3:0] slot_cmd_addr = 4'h1;
  localparam logic [3:0] slot_cmd_data = 4'h2;
  localparam logic [3:0] slot_left = 4'h3;
  localparam logic [3:0] slot_right = 4'h4;
  localparam logic [3:0] slot_modem = 4'h5;
  localparam logic [3:0] slot_center = 4'h6;
  localparam logic [3:0] slot_surr_l = 4'h7;
  localparam logic [3:0] slot_surr_r = 4'h8;
  localparam logic [3:0] slot_lfe = 4'h9;
  localparam logic [3:0] slot_unused = 4'ha;
  localparam logic [3:0] slot_headset = 4'hb;
  localparam logic [3:0] slot_gpio = 4'hc;
  // Tag bit positions
  localparam int unsigned tag_frame_valid = 15;
  localparam int unsigned tag_slot1_valid = 14;
  localparam int unsigned tag_slot3_valid = 12;
  // Slot 1 and slot 12 field positions, primary codec id
  localparam int unsigned cmd_rw_bit = 19;
  localparam int unsigned req_lsb = 2;
  localparam int unsigned req_msb = 11;
  localparam int unsigned gpio_int_bit = 0;
  localparam logic [1:0] primary_codec = 2'h0;

  // Codec register command
  typedef struct packed {
    logic rd;
    logic [6:0] index;
    logic [15:0] wdata;
  } codec_cmd_t;

  // Stereo sample pair, left in upper half
  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } stereo_t;
endpackage

//--- rtl/link_edge_sync.sv
`timescale 1ns/10ps
// Two-flop synchroniser with rise and fall detection
module link_edge_sync
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // Metastability stage, read only by the next flop
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edge pulses from stable samples
  assign level_o = sync_ff;
  assign rise_o = sync_ff & ~prev_ff;
  assign fall_o = ~sync_ff & prev_ff;
endmodule

//--- rtl/slot_deserializer.sv
`timescale 1ns/10ps
// Collects one slot of serial input, MSB first
module slot_deserializer
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic sample_i,
  input wire logic bit_i,
  input wire logic slot_start_i,
  output logic [19:0] word_o
);
  logic [19:0] shift_ff;

  // Shift in on each sample strobe, restart at slot start
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      shift_ff <= 20'h00000;
    else if (sample_i)
    begin
      if (slot_start_i)
        shift_ff <= {19'h00000, bit_i};
      else
        shift_ff <= {shift_ff[18:0], bit_i};
    end
  end

  assign word_o = shift_ff;
endmodule

//--- rtl/ac_link_frame_controller.sv
`timescale 1ns/10ps
// Overview of operation
// - Frames hold a 16-bit tag then twelve 20-bit slots, both ways.
// - Controller makes frame sync; the codec supplies the bit clock.
// - Sync rises from a bit-clock rising edge and stays high 16 clocks.
// - Output data changes on bit-clock rising edges; codec samples falling.
// - Input bits launched on rising edges are captured on falling edges.
// - Slots go MSB first; bits without content are sent as zero.
// - Tag bit 15 marks frame valid; otherwise whole frame is zero.
// - Tag bits 14,13 flag slots 1,2; bits 12..3 flag slots 3..12.
// - Tag bits 1:0 hold codec id; nonzero id clears tag bits 14,13.
// - Invalid slots are zero, except slots 1,2 for a secondary codec.
// - Slot 1: read flag bit 19, index bits 18:12, low bits zero.
// - Slot 2: write data in bits 19:4; all zero on a read.
// - Main playback samples go in slots 3 and 4, MSB first.
// - Record channel takes slots 3 and 4 as one 32-bit stereo word.
// - Modem out feeds slot 5; modem in takes incoming slot 5.
// - Mono out goes to slot 6 or 11; mono in from slot 6 or 11.
// - Surround feeds slots 7 and 8; LFE feeds slot 9.
// - Slot 10 never carries data.
// - Slot 12 carries GPIO output values in bits 19:4.
// - Incoming tag bit 15 is codec ready; next twelve flag slot validity.
// - Incoming slot 1 echoes the register index of the last command.
// - Request flags set mean withhold: tag slot invalid, send no sample; slot 12 ignores its flag and stays valid.
// - Flag bit 11 maps to slot 3 down to bit 2 to slot 12.
// - Incoming slot 2 gives read data in bits 19:4.
// - Incoming slot 12 bit 0 with enable raises the GPIO interrupt flag.
// - Request flags are honoured whether or not slot 1 is tagged valid.
module ac_link_frame_controller
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic codec_bit_clock_i,
  input wire logic serial_data_in_i,
  output logic frame_sync_out_o,
  output logic serial_data_out_o,
  input wire logic link_enable_i,
  input wire logic [1:0] codec_id_i,
  input wire logic cmd_valid_i,
  input wire ac_link_pkg::codec_cmd_t cmd_i,
  output logic cmd_ready_o,
  input wire logic main_playback_channel_valid_i,
  input wire ac_link_pkg::stereo_t main_playback_channel_i,
  output logic main_playback_channel_ready_o,
  input wire logic modem_line_out_channel_valid_i,
  input wire logic [15:0] modem_line_out_channel_i,
  output logic modem_line_out_channel_ready_o,
  input wire logic headset_select_i,
  input wire logic center_or_headset_out_channel_valid_i,
  input wire logic [15:0] center_or_headset_out_channel_i,
  output logic center_or_headset_out_channel_ready_o,
  input wire logic surround_playback_channel_valid_i,
  input wire ac_link_pkg::stereo_t surround_playback_channel_i,
  output logic surround_playback_channel_ready_o,
  input wire logic lfe_playback_channel_valid_i,
  input wire logic [15:0] lfe_playback_channel_i,
  output logic lfe_playback_channel_ready_o,
  input wire logic [15:0] gpio_out_i,
  input wire logic gpio_int_enable_i,
  input wire logic gpio_int_clear_i,
  output logic gpio_int_flag_o,
  output logic [15:0] gpio_in_o,
  output logic codec_ready_o,
  output logic [11:0] in_slot_valid_o,
  output logic status_valid_o,
  output logic [6:0] status_index_o,
  output logic [15:0] status_data_o,
  output logic [9:0] slot_request_flags_o,
  output logic stereo_record_channel_valid_o,
  output ac_link_pkg::stereo_t stereo_record_channel_o,
  output logic modem_line_in_channel_valid_o,
  output logic [15:0] modem_line_in_channel_o,
  output logic mic_or_headset_in_channel_valid_o,
  output logic [15:0] mic_or_headset_in_channel_o
);
  logic bclk_rise;
  logic bclk_fall;
  logic sdin_sync;
  logic [7:0] pos_ff;
  logic [7:0] cap_pos_ff;
  logic cap_run_ff;
  logic running_ff;
  logic sync_ff;
  logic sdo_ff;
  logic [255:0] frame_ff;
  logic [255:0] nxt_frame;
  logic [9:0] req_ff;
  logic [19:0] in_word;
  logic [19:0] shift_word;
  logic [3:0] cap_slot;
  logic cap_start;
  logic cap_end;
  logic [11:0] in_valid_ff;
  logic [11:0] out_valid;
  logic [19:0] slot_word [1:12];
  logic load;

  // Bit clock edges found by the system clock
  link_edge_sync u_bclk
  (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(codec_bit_clock_i),
    .level_o(),
    .rise_o(bclk_rise),
    .fall_o(bclk_fall)
  );

  // Serial input through two flops
  link_edge_sync u_sdin
  (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(serial_data_in_i),
    .level_o(sdin_sync),
    .rise_o(),
    .fall_o()
  );

  // Frame position counter shared by both directions
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      pos_ff <= ac_link_pkg::last_bit;
      running_ff <= 1'b0;
    end
    else if (bclk_rise)
    begin
      if (pos_ff == ac_link_pkg::last_bit)
        running_ff <= link_enable_i;
      if (pos_ff != ac_link_pkg::last_bit || link_enable_i)
        pos_ff <= pos_ff + 8'h01;
    end
  end

  assign load = bclk_rise && pos_ff == ac_link_pkg::last_bit && link_enable_i;

  // Sync and data launched on bit clock rising edges
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      sync_ff <= 1'b0;
      sdo_ff <= 1'b0;
      frame_ff <= '0;
    end
    else if (bclk_rise)
    begin
      if (load)
      begin
        sync_ff <= 1'b1;
        sdo_ff <= nxt_frame[255];
        frame_ff <= {nxt_frame[254:0], 1'b0};
      end
      else
      begin
        if (pos_ff + 8'h01 == ac_link_pkg::sync_len)
          sync_ff <= 1'b0;
        sdo_ff <= frame_ff[255];
        frame_ff <= {frame_ff[254:0], 1'b0};
      end
    end
  end

  assign frame_sync_out_o = sync_ff;
  assign serial_data_out_o = sdo_ff;

  // Slot validity, honouring codec requests whatever slot 1 says
  always_comb
  begin
    out_valid = '0;
    out_valid[0] = cmd_valid_i;
    out_valid[1] = cmd_valid_i && !cmd_i.rd;
    out_valid[2] = main_playback_channel_valid_i && !req_ff[9];
    out_valid[3] = main_playback_channel_valid_i && !req_ff[8];
    out_valid[4] = modem_line_out_channel_valid_i && !req_ff[7];
    out_valid[5] = center_or_headset_out_channel_valid_i && !headset_select_i
      && !req_ff[6];
    out_valid[6] = surround_playback_channel_valid_i && !req_ff[5];
    out_valid[7] = surround_playback_channel_valid_i && !req_ff[4];
    out_valid[8] = lfe_playback_channel_valid_i && !req_ff[3];
    out_valid[9] = 1'b0;
    out_valid[10] = center_or_headset_out_channel_valid_i && headset_select_i
      && !req_ff[1];
    out_valid[11] = 1'b1;
  end

  // Slot contents, zero when invalid
  always_comb
  begin
    for (int s = 1; s <= 12; s++)
      slot_word[s] = 20'h00000;
    if (cmd_valid_i)
    begin
      slot_word[1] = {cmd_i.rd, cmd_i.index, 12'h000};
      if (!cmd_i.rd)
        slot_word[2] = {cmd_i.wdata, 4'h0};
    end
    if (out_valid[2])
      slot_word[3] = {main_playback_channel_i.left, 4'h0};
    if (out_valid[3])
      slot_word[4] = {main_playback_channel_i.right, 4'h0};
    if (out_valid[4])
      slot_word[5] = {modem_line_out_channel_i, 4'h0};
    if (out_valid[5])
      slot_word[6] = {center_or_headset_out_channel_i, 4'h0};
    if (out_valid[6])
      slot_word[7] = {surround_playback_channel_i.left, 4'h0};
    if (out_valid[7])
      slot_word[8] = {surround_playback_channel_i.right, 4'h0};
    if (out_valid[8])
      slot_word[9] = {lfe_playback_channel_i, 4'h0};
    if (out_valid[10])
      slot_word[11] = {center_or_headset_out_channel_i, 4'h0};
    slot_word[12] = {gpio_out_i, 4'h0};
  end

  // Frame assembly: tag then twelve slots
  always_comb
  begin
    nxt_frame = '0;
    nxt_frame[255] = 1'b1;
    nxt_frame[254] = out_valid[0] && codec_id_i == ac_link_pkg::primary_codec;
    nxt_frame[253] = out_valid[1] && codec_id_i == ac_link_pkg::primary_codec;
    nxt_frame[252:243] = {out_valid[2], out_valid[3], out_valid[4], out_valid[5],
      out_valid[6], out_valid[7], out_valid[8], out_valid[9], out_valid[10],
      out_valid[11]};
    nxt_frame[241:240] = codec_id_i;
    for (int s = 1; s <= 12; s++)
      nxt_frame[239 - (s - 1) * 20 -: 20] = slot_word[s];
  end

  // Consumers see ready on the edge that loads their sample
  assign cmd_ready_o = load;
  assign main_playback_channel_ready_o = load && out_valid[2] && out_valid[3];
  assign modem_line_out_channel_ready_o = load && out_valid[4];
  assign center_or_headset_out_channel_ready_o = load && (out_valid[5] || out_valid[10]);
  assign surround_playback_channel_ready_o = load && out_valid[6] && out_valid[7];
  assign lfe_playback_channel_ready_o = load && out_valid[8];

  // Codec answers one bit late: a rise launches the bit of the position it leaves
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      cap_pos_ff <= ac_link_pkg::last_bit;
      cap_run_ff <= 1'b0;
    end
    else if (bclk_rise)
    begin
      cap_pos_ff <= pos_ff;
      cap_run_ff <= running_ff;
    end
  end

  assign cap_slot = (cap_pos_ff < ac_link_pkg::sync_len) ? 4'h0
    : 4'((cap_pos_ff - ac_link_pkg::sync_len) / 8'(ac_link_pkg::slot_bits) + 8'h01);
  assign cap_start = cap_pos_ff == 8'h00 || (cap_pos_ff >= ac_link_pkg::sync_len
    && (cap_pos_ff - ac_link_pkg::sync_len) % 8'(ac_link_pkg::slot_bits) == 8'h00);
  assign cap_end = cap_pos_ff == ac_link_pkg::sync_len - 8'h01
    || (cap_pos_ff >= ac_link_pkg::sync_len
    && (cap_pos_ff - ac_link_pkg::sync_len) % 8'(ac_link_pkg::slot_bits)
    == 8'(ac_link_pkg::slot_bits) - 8'h01);

  slot_deserializer u_deser
  (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .sample_i(bclk_fall && cap_run_ff),
    .bit_i(sdin_sync),
    .slot_start_i(cap_start),
    .word_o(shift_word)
  );

  // Whole slot including the bit taken at this very edge
  assign in_word = {shift_word[18:0], sdin_sync};

  // Slot completion on the falling edge that takes its last bit
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      in_valid_ff <= '0;
      req_ff <= '0;
      codec_ready_o <= 1'b0;
      status_valid_o <= 1'b0;
      status_index_o <= 7'h00;
      status_data_o <= 16'h0000;
      stereo_record_channel_valid_o <= 1'b0;
      stereo_record_channel_o <= '0;
      modem_line_in_channel_valid_o <= 1'b0;
      modem_line_in_channel_o <= 16'h0000;
      mic_or_headset_in_channel_valid_o <= 1'b0;
      mic_or_headset_in_channel_o <= 16'h0000;
      gpio_in_o <= 16'h0000;
    end
    else
    begin
      status_valid_o <= 1'b0;
      stereo_record_channel_valid_o <= 1'b0;
      modem_line_in_channel_valid_o <= 1'b0;
      mic_or_headset_in_channel_valid_o <= 1'b0;
      if (bclk_fall && cap_run_ff && cap_end)
      begin
        case (cap_slot)
          4'h0:
          begin
            codec_ready_o <= in_word[ac_link_pkg::tag_frame_valid];
            in_valid_ff <= in_word[14:3];
          end
          ac_link_pkg::slot_cmd_addr:
          begin
            req_ff <= in_word[ac_link_pkg::req_msb:ac_link_pkg::req_lsb];
            if (in_valid_ff[11])
              status_index_o <= in_word[18:12];
          end
          ac_link_pkg::slot_cmd_data:
          begin
            if (in_valid_ff[10])
            begin
              status_data_o <= in_word[19:4];
              status_valid_o <= 1'b1;
            end
          end
          ac_link_pkg::slot_left:
            if (in_valid_ff[9])
              stereo_record_channel_o.left <= in_word[19:4];
          ac_link_pkg::slot_right:
          begin
            if (in_valid_ff[8])
            begin
              stereo_record_channel_o.right <= in_word[19:4];
              stereo_record_channel_valid_o <= in_valid_ff[9];
            end
          end
          ac_link_pkg::slot_modem:
          begin
            modem_line_in_channel_o <= in_word[19:4];
            modem_line_in_channel_valid_o <= in_valid_ff[7];
          end
          ac_link_pkg::slot_center, ac_link_pkg::slot_headset:
          begin
            if ((cap_slot == ac_link_pkg::slot_headset) == headset_select_i)
            begin
              mic_or_headset_in_channel_o <= in_word[19:4];
              mic_or_headset_in_channel_valid_o <= in_valid_ff[12 - cap_slot];
            end
          end
          ac_link_pkg::slot_gpio:
            gpio_in_o <= in_word[19:4];
          default:
            ;
        endcase
      end
    end
  end

  // Sticky GPIO event flag; a new event wins over a clear
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      gpio_int_flag_o <= 1'b0;
    else if (bclk_fall && cap_run_ff && cap_end && cap_slot == ac_link_pkg::slot_gpio
      && in_word[ac_link_pkg::gpio_int_bit] && gpio_int_enable_i)
      gpio_int_flag_o <= 1'b1;
    else if (gpio_int_clear_i)
      gpio_int_flag_o <= 1'b0;
  end

  assign in_slot_valid_o = in_valid_ff;
  assign slot_request_flags_o = req_ff;

  sequence s_frame_start;
    bclk_rise && pos_ff == ac_link_pkg::last_bit && link_enable_i;
  endsequence

  a_sync_rise: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    s_frame_start |=> frame_sync_out_o && pos_ff == 8'h00)
    else $error("sync did not rise at frame start");
  a_sync_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    frame_sync_out_o |-> pos_ff < ac_link_pkg::sync_len)
    else $error("sync held past sixteen bits");
  a_sync_low: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(frame_sync_out_o) |-> pos_ff == ac_link_pkg::sync_len)
    else $error("sync fell at wrong position");
  a_data_edge: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $changed(serial_data_out_o) |-> $past(bclk_rise))
    else $error("data changed off a rising edge");
  a_frame_valid: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    s_frame_start |=> serial_data_out_o)
    else $error("frame valid bit not sent");
  a_slot10_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    s_frame_start |-> nxt_frame[59:40] == 20'h00000)
    else $error("slot ten not zero");
  a_id_tag: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    codec_id_i != ac_link_pkg::primary_codec |-> nxt_frame[254:253] == 2'h0)
    else $error("slot one tag set for secondary codec");
  a_req_withhold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    req_ff[9] |-> !out_valid[2] && nxt_frame[252] == 1'b0)
    else $error("withheld slot tagged valid");
  a_gpio_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $rose(gpio_int_flag_o) |-> $past(gpio_int_enable_i))
    else $error("gpio flag set while disabled");
endmodule

//--- verification/codec_model.sv
`timescale 1ns/10ps
// Codec stand-in: free bit clock, captures output frames, replays input frames
module codec_model
(
  input wire logic frame_sync_out_i,
  input wire logic serial_data_out_i,
  input wire logic [255:0] in_frame_i,
  output logic codec_bit_clock_o,
  output logic serial_data_in_o,
  output logic [255:0] out_frame_o,
  output int frames_o,
  output int sync_err_o
);
  logic prev_sync;
  logic [255:0] shreg;
  logic [255:0] cur;
  int pos;
  int ipos;
  // Idle state until the first sync
  initial
  begin
    codec_bit_clock_o = 1'b0;
    serial_data_in_o = 1'b0;
    out_frame_o = '0;
    frames_o = 0;
    sync_err_o = 0;
    prev_sync = 1'b0;
    shreg = '0;
    cur = '0;
    pos = 256;
    ipos = 256;
  end
  // Bit clock comes from this side
  always #80 codec_bit_clock_o = ~codec_bit_clock_o;
  // Sync and output data taken on falling edges
  always @(negedge codec_bit_clock_o)
  begin
    if (frame_sync_out_i && !prev_sync)
    begin
      pos = 0;
      ipos = 0;
      cur = in_frame_i;
    end
    if (pos < 256)
    begin
      if (frame_sync_out_i !== (pos < 16))
        sync_err_o++;
      shreg[255 - pos] = serial_data_out_i;
      pos++;
      if (pos == 256)
      begin
        out_frame_o = shreg;
        frames_o++;
      end
    end
    prev_sync = frame_sync_out_i;
  end
  // Input bits launched on rising edges; line keeps changing outside frames
  always @(posedge codec_bit_clock_o)
  begin
    if (ipos < 256)
    begin
      serial_data_in_o <= cur[255 - ipos];
      ipos++;
    end
    else
      serial_data_in_o <= ~serial_data_in_o;
  end
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
// Frame controller bench with a codec model on the link
module testbench;
  logic mclk_i, nrst_i, codec_bit_clock_i, serial_data_in_i, frame_sync_out_o;
  logic serial_data_out_o, link_enable_i, cmd_valid_i, cmd_ready_o, headset_select_i;
  logic [1:0] codec_id_i;
  ac_link_pkg::codec_cmd_t cmd_i, cmd;
  ac_link_pkg::stereo_t main_playback_channel_i, surround_playback_channel_i;
  ac_link_pkg::stereo_t stereo_record_channel_o, pb, sur, rec;
  logic main_playback_channel_valid_i, main_playback_channel_ready_o;
  logic modem_line_out_channel_valid_i, modem_line_out_channel_ready_o;
  logic center_or_headset_out_channel_valid_i, center_or_headset_out_channel_ready_o;
  logic surround_playback_channel_valid_i, surround_playback_channel_ready_o;
  logic lfe_playback_channel_valid_i, lfe_playback_channel_ready_o;
  logic [15:0] modem_line_out_channel_i, center_or_headset_out_channel_i;
  logic [15:0] lfe_playback_channel_i, gpio_out_i, gpio_in_o, status_data_o;
  logic [15:0] modem_line_in_channel_o, mic_or_headset_in_channel_o;
  logic gpio_int_enable_i, gpio_int_clear_i, gpio_int_flag_o, codec_ready_o, status_valid_o;
  logic [11:0] in_slot_valid_o;
  logic [6:0] status_index_o, ridx;
  logic [9:0] slot_request_flags_o, flg;
  logic stereo_record_channel_valid_o, modem_line_in_channel_valid_o;
  logic mic_or_headset_in_channel_valid_o, hs;
  logic [15:0] mo, mn, lf, gpo, rdat, mdin, mic6, mic11, gpin;
  logic [1:0] id;
  logic [287:0] rnd;
  logic [255:0] in_frame, out_frame, fin;
  logic [255:0] q_out [$];
  logic [55:0] q_in [$];
  int frames, sync_err, n_fail, num_checks, dummy, it;

  ac_link_frame_controller ac_link_frame_controller_inst (.*);

  codec_model codec_model_inst (
    .frame_sync_out_i(frame_sync_out_o),
    .serial_data_out_i(serial_data_out_o),
    .in_frame_i(in_frame),
    .codec_bit_clock_o(codec_bit_clock_i),
    .serial_data_in_o(serial_data_in_i),
    .out_frame_o(out_frame),
    .frames_o(frames),
    .sync_err_o(sync_err)
  );

  // System clock
  always #10 mclk_i = ~mclk_i;

  // Compare and count
  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pop_chk(input logic [55:0] seen);
    chk("input result", seen, (q_in.size() > 0) ? q_in.pop_front() : '1);
  endtask

  task give_verdict();
    $display("Checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task wait_frame();
    int f0;
    f0 = frames;
    for (int k = 0; k < 5000 && frames == f0; k++)
      @(posedge mclk_i);
    if (frames == f0)
    begin
      n_fail++;
      give_verdict();
    end
  endtask

  task wait_ready();
    int k;
    k = 0;
    do
    begin
      @(negedge mclk_i);
      k++;
    end
    while (cmd_ready_o !== 1'b1 && k < 5000);
    if (k >= 5000)
    begin
      n_fail++;
      give_verdict();
    end
  endtask

  // Incoming frame as the codec would send it
  function automatic logic [255:0] mk_in(input logic act);
    logic s1;
    s1 = act && !it[0];
    return {1'b1, s1, s1, {4{act}}, 4'h0, act, 1'b1, 3'h0,
      1'b0, s1 ? ridx : 7'h0, flg, 2'h0, s1 ? {rdat, 4'h0} : 20'h0,
      act ? {rec.left, 4'h0, rec.right, 4'h0, mdin, 4'h0, mic6, 4'h0} : 80'h0,
      80'h0, act ? {mic11, 4'h0} : 20'h0, gpin, 3'h0, act & it[0]};
  endfunction

  // Expected outgoing frame for the current stimulus
  function automatic logic [255:0] mk_out();
    logic [19:0] sl [1:12];
    logic [255:0] f;
    logic v;
    f = '0;
    for (int s = 1; s <= 12; s++)
      sl[s] = 20'h0;
    sl[1] = {cmd.rd, cmd.index, 12'h0};
    sl[2] = cmd.rd ? 20'h0 : {cmd.wdata, 4'h0};
    sl[3] = {pb.left, 4'h0};
    sl[4] = {pb.right, 4'h0};
    sl[5] = {mo, 4'h0};
    sl[hs ? 11 : 6] = {mn, 4'h0};
    sl[7] = {sur.left, 4'h0};
    sl[8] = {sur.right, 4'h0};
    sl[9] = {lf, 4'h0};
    sl[12] = {gpo, 4'h0};
    f[255] = 1'b1;
    f[241:240] = id;
    for (int s = 1; s <= 12; s++)
    begin
      v = (s == 2) ? !cmd.rd : (s == 6) ? !hs : (s == 11) ? hs : (s != 10);
      if (s > 2 && s < 12 && flg[12 - s])
        v = 1'b0;
      f[255 - s] = v && (s > 2 || id == 2'h0);
      if (v || s < 3)
        f[239 - 20 * (s - 1) -: 20] = sl[s];
    end
    return f;
  endfunction

  // Output frames against notes
  always @(frames)
    if (q_out.size() > 0)
      chk("output frame", out_frame, q_out.pop_front());

  // Input side pulses against notes
  always @(negedge mclk_i)
  begin
    if (status_valid_o === 1'b1)
      pop_chk({8'h1, 25'h0, status_index_o, status_data_o});
    if (stereo_record_channel_valid_o === 1'b1)
      pop_chk({8'h2, 3'h0, codec_ready_o, in_slot_valid_o, stereo_record_channel_o});
    if (modem_line_in_channel_valid_o === 1'b1)
      pop_chk({8'h3, 32'h0, modem_line_in_channel_o});
    if (mic_or_headset_in_channel_valid_o === 1'b1)
      pop_chk({8'h4, 32'h0, mic_or_headset_in_channel_o});
  end

  // Main sequence
  initial
  begin
    {mclk_i, nrst_i, link_enable_i, codec_id_i, cmd_valid_i, headset_select_i} = '0;
    {cmd_i, main_playback_channel_i, surround_playback_channel_i, gpio_out_i} = '0;
    {modem_line_out_channel_i, center_or_headset_out_channel_i, lfe_playback_channel_i} = '0;
    {main_playback_channel_valid_i, modem_line_out_channel_valid_i} = '0;
    {center_or_headset_out_channel_valid_i, surround_playback_channel_valid_i} = '0;
    {lfe_playback_channel_valid_i, gpio_int_enable_i, gpio_int_clear_i, in_frame, rnd} = '0;
    {n_fail, num_checks, it, flg, hs, gpin} = '0;
    dummy = $urandom(32'h333f);
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1'b1;
    link_enable_i <= 1'b1;
    in_frame <= mk_in(1'b0);
    for (int i = 0; i < 4; i++)
    begin
      wait_frame();
      it = i;
      id = i[1:0];
      hs = i[1];
      for (int k = 0; k < 9; k++)
        rnd = {rnd[255:0], $urandom};
      {pb, sur, rec, mo, mn, lf, gpo, ridx, rdat, mdin, mic6, mic11, gpin} = rnd[269:23];
      {cmd.index, cmd.wdata} = rnd[22:0];
      cmd.rd = i[0];
      flg = (i < 2) ? 10'h0 : (rnd[279:270] | 10'h005);
      flg[8] = flg[9];
      flg[4] = flg[5];
      fin = mk_in(1'b1);
      codec_id_i <= id;
      headset_select_i <= hs;
      gpio_int_enable_i <= i[1];
      gpio_int_clear_i <= 1'b1;
      gpio_out_i <= gpo;
      in_frame <= fin;
      if (!i[0])
        q_in.push_back({8'h1, 25'h0, ridx, rdat});
      q_in.push_back({8'h2, 3'h0, fin[255:243], rec});
      q_in.push_back({8'h3, 32'h0, mdin});
      q_in.push_back({8'h4, 32'h0, hs ? mic11 : mic6});
      @(posedge mclk_i);
      gpio_int_clear_i <= 1'b0;
      wait_frame();
      in_frame <= mk_in(1'b0);
      cmd_i <= cmd;
      main_playback_channel_i <= pb;
      surround_playback_channel_i <= sur;
      modem_line_out_channel_i <= mo;
      center_or_headset_out_channel_i <= mn;
      lfe_playback_channel_i <= lf;
      {cmd_valid_i, main_playback_channel_valid_i, modem_line_out_channel_valid_i} <= 3'h7;
      {center_or_headset_out_channel_valid_i, surround_playback_channel_valid_i} <= 2'h3;
      lfe_playback_channel_valid_i <= 1'b1;
      wait_ready();
      chk("ready", {main_playback_channel_ready_o, modem_line_out_channel_ready_o,
        center_or_headset_out_channel_ready_o, surround_playback_channel_ready_o,
        lfe_playback_channel_ready_o},
        5'(~{flg[9], flg[7], hs ? flg[1] : flg[6], flg[5], flg[3]}));
      q_out.push_back(mk_out());
      @(posedge mclk_i);
      {cmd_valid_i, main_playback_channel_valid_i, modem_line_out_channel_valid_i} <= 3'h0;
      {center_or_headset_out_channel_valid_i, surround_playback_channel_valid_i} <= 2'h0;
      lfe_playback_channel_valid_i <= 1'b0;
      wait_frame();
      chk("gpio and requests", {gpio_int_flag_o, gpio_in_o, slot_request_flags_o},
        {i == 3, gpin, flg});
    end
    wait_frame();
    chk("sync width", sync_err, 0);
    chk("pending results", q_in.size() + q_out.size(), 0);
    give_verdict();
  end
endmodule
